// ### qpot_pkg.sv
/*
 Package for the quad potentiometer serial command unit: identification
 layout, opcodes, state encoding and timing counts.
 Assumes a 125 MHz core clock sampling a slower serial link.
*/
package qpot_pkg;
   // ****************************************
   // Identification byte
   // ****************************************
   // Device type code: arbitrary neutral value
   localparam logic [3:0] QPOT_TYPE_CODE = 4'hA;
   localparam int QPOT_ID_TYPE_LSB = 4;
   localparam int QPOT_ID_SEL_LSB = 0;

   // ****************************************
   // Instruction byte fields
   // ****************************************
   localparam int QPOT_OP_LSB = 4;
   localparam int QPOT_IDX_LSB = 2;
   localparam int QPOT_POT_LSB = 0;

   localparam logic [3:0] QPOT_OP_RD_WIPER = 4'h9;
   localparam logic [3:0] QPOT_OP_WR_WIPER = 4'hA;
   localparam logic [3:0] QPOT_OP_RD_SET = 4'hB;
   localparam logic [3:0] QPOT_OP_WR_SET = 4'hC;
   localparam logic [3:0] QPOT_OP_SET_TO_WIPER = 4'hD;
   localparam logic [3:0] QPOT_OP_WIPER_TO_SET = 4'hE;
   localparam logic [3:0] QPOT_OP_GSET_TO_WIPER = 4'h1;
   localparam logic [3:0] QPOT_OP_GWIPER_TO_SET = 4'h8;
   localparam logic [3:0] QPOT_OP_STEP = 4'h2;
   localparam logic [3:0] QPOT_OP_STATUS = 4'h5;

   // ****************************************
   // Frame states
   // ****************************************
   typedef enum logic [2:0]
   {
      QPOT_ST_ID = 3'b000,
      QPOT_ST_INSTR = 3'b001,
      QPOT_ST_DATA = 3'b010,
      QPOT_ST_STEP = 3'b011,
      QPOT_ST_DONE = 3'b100,
      QPOT_ST_IGNORE = 3'b101
   } qpot_state_e;

   // ****************************************
   // Timing
   // ****************************************
   localparam int QPOT_CLK_MHZ = 125;
   localparam int QPOT_NV_WRITE_MS = 10;
   localparam int QPOT_NV_WRITE_CYC = QPOT_NV_WRITE_MS * 1000 * QPOT_CLK_MHZ;
   localparam int QPOT_WIPER_DELAY_NS = 200;
   localparam int QPOT_WIPER_DELAY_CYC = (QPOT_WIPER_DELAY_NS * QPOT_CLK_MHZ) / 1000;
endpackage

// ### qpot_tap_decode.sv
/*
 One-hot tap decoder for one potentiometer array.
 Assumes a registered wiper position at its input.
*/
`timescale 1ns/1ps
module qpot_tap_decode
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Position in
   input wire logic [7:0] position,
   // Tap switches out
   output logic [255:0] taps
);
   // Registered so exactly one switch is ever closed, with no decode glitches
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         taps <= 256'h1;
      end
      else
      begin
         taps <= 256'h1 << position; // [RQ4]
      end
   end
endmodule

// ### qpot_cmd_unit.sv
/*
 Serial command front end of a quad digital potentiometer: frames,
 decodes and executes commands on four wiper and sixteen setting registers.
 Assumes link pins are asynchronous to mclk and are synchronised here;
 rst stands for power-up.
*/
// Function
// RQ1 - Write lock low blocks setting writes
// RQ2 - Sample input on rising link clock
// RQ3 - Output tri-state unless returning read data
// RQ4 - Wiper decoded one-hot over 256 taps
// RQ5 - Power-up loads wiper from setting zero
// RQ6 - Four readable writable setting registers per pot
// RQ7 - Setting write finishes within ten ms
// RQ8 - Store starts at select rise, complete only
// RQ9 - Write pending flag readable by status
// RQ10 - Identification byte first with type code
// RQ11 - Select bits must match bus select pins
// RQ12 - Host sends middle identification bits zero
// RQ13 - Instruction byte: op, index, pot
// RQ14 - Copy commands end after instruction byte
// RQ15 - Global copy acts on all pots
// RQ16 - Wiper moves after response delay
// RQ17 - Wiper to setting copy is nonvolatile
// RQ18 - Reads shift out, writes shift in third byte
// RQ19 - Step command moves wiper per clock pulse
// RQ20 - Stepping saturates at end taps
// RQ21 - Mismatched identification ignores rest of frame
// RQ22 - Output data changes on falling link clock
// RQ23 - Pause input freezes frame state
// RQ24 - Deselected: tri-state, standby unless writing
// RQ25 - No command before first select fall
`timescale 1ns/1ps
module qpot_cmd_unit
#(
   parameter int NV_WRITE_CYC = qpot_pkg::QPOT_NV_WRITE_CYC
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Serial link pins
   input wire logic link_clk,
   input wire logic select_n,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   input wire logic pause_n,
   input wire logic write_lock_n,
   input wire logic [1:0] bus_select_pins,
   // Status
   output logic write_pending_flag,
   output logic standby,
   // Analog switch control
   output logic [255:0] taps0,
   output logic [255:0] taps1,
   output logic [255:0] taps2,
   output logic [255:0] taps3
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic [1:0] addr1_r;
   logic [1:0] addr2_r;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sync1_r <= 5'h1F;
         sync2_r <= 5'h1F;
         addr1_r <= 2'h0;
         addr2_r <= 2'h0;
      end
      else
      begin
         sync1_r <= {link_clk, select_n, serial_in, pause_n, write_lock_n};
         sync2_r <= sync1_r;
         addr1_r <= bus_select_pins;
         addr2_r <= addr1_r;
      end
   end
   logic sck_s, sel_n_s, si_s, pause_n_s, lock_n_s;
   assign sck_s = sync2_r[4];
   assign sel_n_s = sync2_r[3];
   assign si_s = sync2_r[2];
   assign pause_n_s = sync2_r[1];
   assign lock_n_s = sync2_r[0];

   logic sck_d_r, sel_d_r;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sck_d_r <= 1'b0;
         sel_d_r <= 1'b1;
      end
      else
      begin
         sck_d_r <= sck_s;
         sel_d_r <= sel_n_s;
      end
   end
   // Link clock edges are ignored while paused so the frame state freezes
   logic sck_rise, sck_fall, sel_fall, sel_rise, active;
   assign active = ~sel_n_s & pause_n_s; // [RQ23]
   assign sck_rise = active & sck_s & ~sck_d_r; // [RQ2]
   assign sck_fall = active & ~sck_s & sck_d_r;
   assign sel_fall = sel_d_r & ~sel_n_s;
   assign sel_rise = ~sel_d_r & sel_n_s;

   // ****************************************
   // Storage
   // ****************************************
   logic [7:0] wiper_position_register [4];
   // Blank cells at first power-up; rst leaves them alone since they stand for nonvolatile storage
   logic [7:0] nv_setting_register [16] = '{default: 8'h00}; // [RQ6]

   // ****************************************
   // Frame decoder
   // ****************************************
   qpot_pkg::qpot_state_e state_r;
   logic armed_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] instr_r;
   logic [7:0] out_r;
   logic drive_r;
   logic complete_r;
   logic [7:0] byte_in;
   logic byte_done;
   logic [3:0] op;
   logic [1:0] idx, pot;
   logic [3:0] nv_addr;

   assign byte_in = {shift_r[6:0], si_s};
   assign byte_done = sck_rise & (bit_cnt_r == 3'd7);
   assign op = instr_r[qpot_pkg::QPOT_OP_LSB +: 4];
   assign idx = instr_r[qpot_pkg::QPOT_IDX_LSB +: 2];
   assign pot = instr_r[qpot_pkg::QPOT_POT_LSB +: 2];
   assign nv_addr = {pot, idx};

   // Opcode of the byte just finished in the instruction state
   logic [3:0] new_op;
   assign new_op = byte_in[qpot_pkg::QPOT_OP_LSB +: 4];

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_r <= qpot_pkg::QPOT_ST_IGNORE;
         armed_r <= 1'b0;
         bit_cnt_r <= 3'd0;
         shift_r <= 8'h00;
         instr_r <= 8'h00;
         complete_r <= 1'b0;
      end
      else if (sel_n_s)
      begin
         state_r <= qpot_pkg::QPOT_ST_IGNORE;
         bit_cnt_r <= 3'd0;
         complete_r <= 1'b0;
      end
      else if (sel_fall)
      begin
         state_r <= qpot_pkg::QPOT_ST_ID;
         armed_r <= 1'b1; // [RQ25]
         bit_cnt_r <= 3'd0;
         complete_r <= 1'b0;
      end
      else if (sck_rise)
      begin
         shift_r <= byte_in;
         bit_cnt_r <= bit_cnt_r + 3'd1;
         unique case (state_r)
            qpot_pkg::QPOT_ST_ID:
            begin
               if (byte_done)
               begin
                  // Middle bits are the host's to keep zero; only type and select are checked
                  if (armed_r && byte_in[qpot_pkg::QPOT_ID_TYPE_LSB +: 4] == qpot_pkg::QPOT_TYPE_CODE // [RQ10]
                      && byte_in[qpot_pkg::QPOT_ID_SEL_LSB +: 2] == addr2_r) // [RQ11] [RQ12]
                     state_r <= qpot_pkg::QPOT_ST_INSTR;
                  else
                     state_r <= qpot_pkg::QPOT_ST_IGNORE; // [RQ21]
               end
            end
            qpot_pkg::QPOT_ST_INSTR:
            begin
               if (byte_done)
               begin
                  instr_r <= byte_in; // [RQ13]
                  unique case (new_op)
                     qpot_pkg::QPOT_OP_SET_TO_WIPER, qpot_pkg::QPOT_OP_WIPER_TO_SET,
                     qpot_pkg::QPOT_OP_GSET_TO_WIPER, qpot_pkg::QPOT_OP_GWIPER_TO_SET:
                     begin
                        state_r <= qpot_pkg::QPOT_ST_DONE; // [RQ14]
                        complete_r <= 1'b1;
                     end
                     qpot_pkg::QPOT_OP_RD_WIPER, qpot_pkg::QPOT_OP_WR_WIPER, qpot_pkg::QPOT_OP_RD_SET,
                     qpot_pkg::QPOT_OP_WR_SET, qpot_pkg::QPOT_OP_STATUS:
                        state_r <= qpot_pkg::QPOT_ST_DATA; // [RQ18]
                     qpot_pkg::QPOT_OP_STEP:
                        state_r <= qpot_pkg::QPOT_ST_STEP;
                     default:
                        state_r <= qpot_pkg::QPOT_ST_IGNORE;
                  endcase
               end
            end
            qpot_pkg::QPOT_ST_DATA:
            begin
               if (byte_done)
               begin
                  state_r <= qpot_pkg::QPOT_ST_DONE;
                  complete_r <= 1'b1;
               end
            end
            qpot_pkg::QPOT_ST_STEP, qpot_pkg::QPOT_ST_DONE, qpot_pkg::QPOT_ST_IGNORE:
               state_r <= state_r;
            default:
               state_r <= qpot_pkg::QPOT_ST_IGNORE;
         endcase
      end
   end

   // ****************************************
   // Read data path
   // ****************************************
   logic reading;
   assign reading = (op == qpot_pkg::QPOT_OP_RD_WIPER) | (op == qpot_pkg::QPOT_OP_RD_SET)
                    | (op == qpot_pkg::QPOT_OP_STATUS);
   logic [7:0] read_word;
   always_comb
   begin
      unique case (op)
         qpot_pkg::QPOT_OP_RD_WIPER: read_word = wiper_position_register[pot];
         qpot_pkg::QPOT_OP_RD_SET: read_word = nv_setting_register[nv_addr];
         default: read_word = {7'h00, write_pending_flag}; // [RQ9]
      endcase
   end
   always_ff @(posedge mclk)
   begin
      if (rst || sel_n_s)
      begin
         out_r <= 8'h00;
         drive_r <= 1'b0;
         serial_out <= 1'b0;
      end
      else if (sck_fall)
      begin
         // First falling edge after the instruction byte loads the word
         if (state_r == qpot_pkg::QPOT_ST_DATA && bit_cnt_r == 3'd0 && !drive_r && reading)
         begin
            out_r <= {read_word[6:0], 1'b0};
            drive_r <= 1'b1;
            serial_out <= read_word[7]; // [RQ22]
         end
         else if (drive_r && state_r == qpot_pkg::QPOT_ST_DATA)
         begin
            serial_out <= out_r[7];
            out_r <= {out_r[6:0], 1'b0};
         end
         else
         begin
            drive_r <= 1'b0;
         end
      end
   end
   assign serial_out_oe = drive_r & ~sel_n_s; // [RQ3] [RQ24]

   // ****************************************
   // Nonvolatile write timer
   // ****************************************
   logic [31:0] nv_cnt_r;
   always_ff @(posedge mclk)
   begin
      if (rst)
         nv_cnt_r <= 32'h0;
      else if (sel_rise && complete_r && lock_n_s // [RQ1] [RQ8]
               && (op == qpot_pkg::QPOT_OP_WR_SET || op == qpot_pkg::QPOT_OP_WIPER_TO_SET
                   || op == qpot_pkg::QPOT_OP_GWIPER_TO_SET))
         nv_cnt_r <= 32'(NV_WRITE_CYC); // [RQ7] [RQ17]
      else if (nv_cnt_r != 32'h0)
         nv_cnt_r <= nv_cnt_r - 32'h1;
   end
   assign write_pending_flag = (nv_cnt_r != 32'h0); // [RQ9]
   assign standby = sel_n_s & ~write_pending_flag; // [RQ24]

   // ****************************************
   // Setting registers
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (sel_rise && complete_r && lock_n_s && !rst) // [RQ1] [RQ8]
      begin
         unique case (op)
            qpot_pkg::QPOT_OP_WR_SET: nv_setting_register[nv_addr] <= shift_r;
            qpot_pkg::QPOT_OP_WIPER_TO_SET: nv_setting_register[nv_addr] <= wiper_position_register[pot];
            qpot_pkg::QPOT_OP_GWIPER_TO_SET:
               for (int p = 0; p < 4; p++)
                  nv_setting_register[{p[1:0], idx}] <= wiper_position_register[p]; // [RQ15]
            default: nv_setting_register[0] <= nv_setting_register[0];
         endcase
      end
   end

   // ****************************************
   // Wiper registers
   // ****************************************
   logic [7:0] wiper_delay_r;
   logic [3:0] load_mask_r;
   logic recall_r;
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         recall_r <= 1'b1;
         load_mask_r <= 4'h0;
         wiper_delay_r <= 8'h00;
      end
      else
      begin
         recall_r <= 1'b0;
         if (wiper_delay_r != 8'h00)
            wiper_delay_r <= wiper_delay_r - 8'h01;
         else
            load_mask_r <= 4'h0;
         if (state_r == qpot_pkg::QPOT_ST_INSTR && byte_done && sel_n_s == 1'b0 && !sel_fall)
         begin
            if (new_op == qpot_pkg::QPOT_OP_SET_TO_WIPER || new_op == qpot_pkg::QPOT_OP_GSET_TO_WIPER)
            begin
               load_mask_r <= (new_op == qpot_pkg::QPOT_OP_GSET_TO_WIPER) ? 4'hF
                              : (4'h1 << byte_in[qpot_pkg::QPOT_POT_LSB +: 2]);
               wiper_delay_r <= 8'(qpot_pkg::QPOT_WIPER_DELAY_CYC); // [RQ16]
            end
         end
      end
   end
   logic [1:0] st_idx;
   assign st_idx = instr_r[qpot_pkg::QPOT_IDX_LSB +: 2];
   always_ff @(posedge mclk)
   begin
      for (int p = 0; p < 4; p++)
      begin
         if (recall_r)
            wiper_position_register[p] <= nv_setting_register[{p[1:0], 2'b00}]; // [RQ5]
         else if (load_mask_r[p] && wiper_delay_r == 8'h01)
            wiper_position_register[p] <= nv_setting_register[{p[1:0], st_idx}]; // [RQ15] [RQ16]
         else if (pot == p[1:0] && state_r == qpot_pkg::QPOT_ST_DATA && byte_done
                  && op == qpot_pkg::QPOT_OP_WR_WIPER && !sel_n_s)
            wiper_position_register[p] <= byte_in;
         else if (pot == p[1:0] && state_r == qpot_pkg::QPOT_ST_STEP && sck_rise)
         begin
            if (si_s && wiper_position_register[p] != 8'hFF) // [RQ19] [RQ20]
               wiper_position_register[p] <= wiper_position_register[p] + 8'h01;
            else if (!si_s && wiper_position_register[p] != 8'h00)
               wiper_position_register[p] <= wiper_position_register[p] - 8'h01;
         end
      end
   end

   // ****************************************
   // Tap decoders
   // ****************************************
   qpot_tap_decode u_dec0 (.mclk(mclk), .rst(rst), .position(wiper_position_register[0]), .taps(taps0));
   qpot_tap_decode u_dec1 (.mclk(mclk), .rst(rst), .position(wiper_position_register[1]), .taps(taps1));
   qpot_tap_decode u_dec2 (.mclk(mclk), .rst(rst), .position(wiper_position_register[2]), .taps(taps2));
   qpot_tap_decode u_dec3 (.mclk(mclk), .rst(rst), .position(wiper_position_register[3]), .taps(taps3));
endmodule

// ### qpot_cmd_unit_monitor.sv
/*
 Checker for the quad potentiometer command unit, bound to its ports.
 Assumes mclk is the only clock and rst is synchronous.
*/
`timescale 1ns/1ps
module qpot_cmd_unit_monitor
#(
   parameter int NV_WRITE_CYC = 100
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Link
   input wire logic link_clk,
   input wire logic select_n,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic pause_n,
   input wire logic write_lock_n,
   input wire logic [1:0] bus_select_pins,
   // Status and taps
   input wire logic write_pending_flag,
   input wire logic standby,
   input wire logic [255:0] taps0,
   input wire logic [255:0] taps1,
   input wire logic [255:0] taps2,
   input wire logic [255:0] taps3
);
   // ****************************************
   // Properties
   // ****************************************
   int wip_cnt;

   // Counter length stands in for a repetition, too long to unroll
   always_ff @(posedge mclk)
   begin
      if (rst || !write_pending_flag)
         wip_cnt <= 0;
      else
         wip_cnt <= wip_cnt + 1;
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_sel_rise;
      $rose(select_n);
   endsequence
   sequence s_store_start;
      $rose(write_pending_flag);
   endsequence

   property p_oe_off;
      s_sel_rise |-> ##[1:5] !serial_out_oe;
   endproperty
   property p_oe_sel;
      $rose(serial_out_oe) |-> !select_n;
   endproperty
   property p_so_fall;
      serial_out_oe && $changed(serial_out) |-> !link_clk && !$past(link_clk, 2);
   endproperty
   property p_standby_wip;
      write_pending_flag |-> !standby;
   endproperty
   property p_standby_sel;
      (!select_n) [*5] |-> !standby;
   endproperty
   property p_store_sel;
      s_store_start |-> select_n && write_lock_n;
   endproperty
   property p_wip_max;
      write_pending_flag |-> wip_cnt <= NV_WRITE_CYC;
   endproperty
   property p_wip_min;
      $fell(write_pending_flag) |-> $past(wip_cnt) >= NV_WRITE_CYC - 2;
   endproperty
   property p_onehot;
      $onehot(taps0) && $onehot(taps1) && $onehot(taps2) && $onehot(taps3);
   endproperty

   a_oe_off: assert property (p_oe_off) else $error("output enabled after deselect");
   a_oe_sel: assert property (p_oe_sel) else $error("output enabled while deselected");
   a_so_fall: assert property (p_so_fall) else $error("read bit changed off falling edge");
   a_standby_wip: assert property (p_standby_wip) else $error("standby during store");
   a_standby_sel: assert property (p_standby_sel) else $error("standby while selected");
   a_store_sel: assert property (p_store_sel) else $error("store start not at select rise");
   a_wip_max: assert property (p_wip_max) else $error("store too long");
   a_wip_min: assert property (p_wip_min) else $error("store too short");
   a_onehot: assert property (p_onehot) else $error("taps not one-hot");
endmodule

bind qpot_cmd_unit qpot_cmd_unit_monitor #(.NV_WRITE_CYC(NV_WRITE_CYC)) i_qpot_cmd_unit_monitor
(
   .mclk(mclk), .rst(rst), .link_clk(link_clk), .select_n(select_n), .serial_in(serial_in),
   .serial_out(serial_out), .serial_out_oe(serial_out_oe), .pause_n(pause_n), .write_lock_n(write_lock_n),
   .bus_select_pins(bus_select_pins), .write_pending_flag(write_pending_flag), .standby(standby),
   .taps0(taps0), .taps1(taps1), .taps2(taps2), .taps3(taps3)
);

// ### qpot_host_model.sv
/*
 Serial host model: frames commands to the potentiometer unit.
 Assumes mclk at 125 MHz; link clock half period is 10 mclk (80 ns).
*/
`timescale 1ns/1ps
module qpot_host_model
(
   // Clock
   input wire logic mclk,
   // Link
   output logic link_clk,
   output logic select_n,
   output logic serial_in,
   output logic pause_n,
   input wire logic serial_out
);
   // ****************************************
   // Frames
   // ****************************************
   initial
   begin
      link_clk = 1'b0;
      select_n = 1'b1;
      serial_in = 1'b0;
      pause_n = 1'b1;
   end

   task automatic half();
      repeat (10) @(negedge mclk);
   endtask

   // Bits leave MSB first from bit 23; bits past 16 capture read data
   task automatic frame(input logic [23:0] d, input int nb, input int pz, output logic [7:0] rd);
      rd = 8'h00;
      select_n <= 1'b0;
      for (int i = 0; i < nb; i++)
      begin
         serial_in <= d[23 - i];
         half();
         link_clk <= 1'b1;
         if (i >= 16)
            rd = {rd[6:0], serial_out};
         half();
         link_clk <= 1'b0;
         if (i == pz)
         begin
            pause_n <= 1'b0;
            half();
            link_clk <= 1'b1;
            half();
            link_clk <= 1'b0;
            half();
            pause_n <= 1'b1;
         end
      end
      half();
      // Released data line flips so a stale level is never taken as data
      serial_in <= ~serial_in;
      select_n <= 1'b1;
      half();
      half();
   endtask
endmodule

// ### qpot_cmd_unit_tb.sv
/*
 Self-checking bench for the potentiometer command unit.
 Assumes the host model and the bound checker; store time shortened to 1000
 cycles, long enough to outlast a following status frame.
*/
`timescale 1ns/1ps
module qpot_cmd_unit_tb;
   typedef struct {logic [23:0] d; int nb; logic chk; logic [7:0] e;} qpot_row_s;

   logic mclk, rst, link_clk, select_n, serial_in, serial_out, serial_out_oe, pause_n;
   logic write_lock_n, write_pending_flag, standby;
   logic [1:0] bus_select_pins;
   logic [255:0] taps0, taps1, taps2, taps3;
   logic [7:0] rd;
   int n_mismatch, total_checks;

   qpot_row_s rows [28] = '{
      '{24'hA2A15A, 24, 1'b0, 8'h00}, '{24'hA29100, 24, 1'b1, 8'h5A},
      '{24'hA2CEC3, 24, 1'b0, 8'h00}, '{24'hA2BE00, 24, 1'b1, 8'hC3},
      '{24'hA2DE00, 16, 1'b0, 8'h00}, '{24'hA29200, 24, 1'b1, 8'hC3},
      '{24'hA2A011, 24, 1'b0, 8'h00}, '{24'hA2E400, 16, 1'b0, 8'h00},
      '{24'hA2B400, 24, 1'b1, 8'h11}, '{24'hA2A377, 24, 1'b0, 8'h00},
      '{24'hA28800, 16, 1'b0, 8'h00}, '{24'hA2BB00, 24, 1'b1, 8'h77},
      '{24'hA2B900, 24, 1'b1, 8'h5A}, '{24'hA2A300, 24, 1'b0, 8'h00},
      '{24'hA21800, 16, 1'b0, 8'h00}, '{24'hA29300, 24, 1'b1, 8'h77},
      '{24'hA25100, 24, 1'b1, 8'h00}, '{24'hA1A100, 24, 1'b0, 8'h00},
      '{24'h72A100, 24, 1'b0, 8'h00}, '{24'hA29100, 24, 1'b1, 8'h5A},
      '{24'hA2A0FE, 24, 1'b0, 8'h00}, '{24'hA220E0, 19, 1'b0, 8'h00},
      '{24'hA29000, 24, 1'b1, 8'hFF}, '{24'hA22000, 24, 1'b0, 8'h00},
      '{24'hA29000, 24, 1'b1, 8'hF7}, '{24'hA2A001, 24, 1'b0, 8'h00},
      '{24'hA22000, 24, 1'b0, 8'h00}, '{24'hA29000, 24, 1'b1, 8'h00}
   };

   qpot_cmd_unit #(.NV_WRITE_CYC(1000)) i_qpot_cmd_unit
   (
      .mclk(mclk), .rst(rst), .link_clk(link_clk), .select_n(select_n), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe), .pause_n(pause_n), .write_lock_n(write_lock_n),
      .bus_select_pins(bus_select_pins), .write_pending_flag(write_pending_flag), .standby(standby),
      .taps0(taps0), .taps1(taps1), .taps2(taps2), .taps3(taps3)
   );

   qpot_host_model i_qpot_host_model
   (
      .mclk(mclk), .link_clk(link_clk), .select_n(select_n), .serial_in(serial_in), .pause_n(pause_n),
      .serial_out(serial_out)
   );

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_taps(input string nm, input logic [255:0] e, input logic [255:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic xfer(input logic [23:0] d, input int nb, input int pz);
      i_qpot_host_model.frame(d, nb, pz, rd);
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      while (write_pending_flag !== 1'b0 && k < 2000)
      begin
         @(negedge mclk);
         k++;
      end
      if (k == 2000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // ****************************************
   // Sequence
   // ****************************************
   initial
   begin
      rst = 1'b1;
      write_lock_n = 1'b1;
      bus_select_pins = 2'b10;
      n_mismatch = 0;
      total_checks = 0;
      repeat (8) @(negedge mclk);
      rst <= 1'b0;
      repeat (4) @(negedge mclk);
      foreach (rows[i])
      begin
         xfer(rows[i].d, rows[i].nb, -1);
         wait_idle();
         if (rows[i].chk)
            chk_byte("read", rows[i].e, rd);
         $display("row %0d done", i);
      end
      // Cut-short write must leave the setting alone
      xfer(24'hA2C455, 20, -1);
      wait_idle();
      xfer(24'hA2B400, 24, -1);
      chk_byte("partial", 8'h11, rd);
      $display("partial done");
      write_lock_n <= 1'b0;
      xfer(24'hA2C499, 24, -1);
      chk_byte("lock_wip", 8'h00, {7'h00, write_pending_flag});
      write_lock_n <= 1'b1;
      xfer(24'hA2B400, 24, -1);
      chk_byte("lock", 8'h11, rd);
      $display("lock done");
      xfer(24'hA2C842, 24, -1);
      chk_byte("standby_wip", 8'h00, {7'h00, standby});
      xfer(24'hA25100, 24, -1);
      chk_byte("status", 8'h01, rd);
      wait_idle();
      chk_byte("standby", 8'h01, {7'h00, standby});
      xfer(24'hA2B800, 24, -1);
      chk_byte("set", 8'h42, rd);
      $display("status done");
      xfer(24'hA2A166, 24, 11);
      xfer(24'hA29100, 24, -1);
      chk_byte("pause", 8'h66, rd);
      $display("pause done");
      xfer(24'hA2C33C, 24, -1);
      wait_idle();
      rst <= 1'b1;
      repeat (8) @(negedge mclk);
      rst <= 1'b0;
      repeat (40) @(negedge mclk);
      chk_taps("taps3", 256'h1 << 8'h3C, taps3);
      xfer(24'hA29300, 24, -1);
      chk_byte("recall", 8'h3C, rd);
      $display("recall done");
      report_and_stop();
   end
endmodule
